// [core/port_b_override_regs.vh]
// Purpose: constants for the port b alternate function override block
// Assumes: included by core design files only
// Notes:   override constant values and synchroniser reset state
`ifndef PORT_B_OVERRIDE_REGS_VH
`define PORT_B_OVERRIDE_REGS_VH

`define OVR_OFF        1'h0
`define OVR_ON         1'h1
`define PULLUP_RST_VAL 1'h1
`define SYNC_RST_VAL   1'h0
`define OUT_RST_VAL    1'h0

// positions of the pins inside the bits 7..4 override vectors
`define HI_B7          2'h3
`define HI_B6          2'h2
`define HI_B5          2'h1
`define HI_B4          2'h0

`endif

// [core/pin_sync2.v]
// Purpose: two flip-flop synchroniser for WIDTH pin levels
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`include "port_b_override_regs.vh"

module pin_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // data
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // double flop against metastability
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= {WIDTH{`SYNC_RST_VAL}};
      sync_r <= {WIDTH{`SYNC_RST_VAL}};
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // pin_sync2

// [core/port_b_alt_function_override.v]
// Purpose: override terms for port bit 0 and bits 7..4 alternate functions
// Assumes: all control inputs are same-clock logic; pad inputs are asynchronous
// Notes:   every output is registered, so overrides lag their causes by one cycle
//
// Functional notes
// - three-wire serial mode leaves bit 0 port controls unchanged; software sets it input.
// - two-wire mode bit 0 drives low when latch or shift output zero and direction set.
// - two-wire mode keeps bit 0 pull-up disabled regardless of output latch.
// - bit 0 carries inverted timer1 wave A only when not serial/programming and direction set.
// - bit 0 pin-change needs global irq and group0 enable, masked by owning functions.
// - bit 0 input buffer stays on in sleep when pin-change enabled and unmasked.
// - bit 7 reset function forces pull-up on, direction input, never output value.
// - bit 7 input override on for group1 or reset; value only group1 without reset.
// - group1 active needs global irq, group1 mask flag, and no occupying alternate function.
// - bit 6 input override value 1; enabled by ext irq0 or group1 without timer0 clock.
// - timer0 outside clock masks pin-change sensing on bit 6.
// - bits 5,4 without io permit override pull-up and direction to 0; input per group1.
// - bit 4 outside clock source forces input override enable and value true.
`timescale 1ns/1ps
`include "port_b_override_regs.vh"

module port_b_alt_function_override (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // port bit 0 controls
  input  wire       port_bit0_out_latch,
  input  wire       port_bit0_out_en,
  // serial interface
  input  wire       serial_two_wire_mode,
  input  wire       serial_three_wire_mode,
  input  wire       serial_shift_out,
  input  wire       serial_start_irq_active,
  input  wire       programming_active,
  // timer1
  input  wire       timer1_compare_a_en,
  input  wire       timer1_compare_a_wave,
  // interrupt controls
  input  wire       global_irq_en,
  input  wire       group0_change_irq_en,
  input  wire       group1_change_irq_en,
  input  wire       ext_irq0_active,
  input  wire       timer0_outside_clock_sel,
  // fuse terms
  input  wire       reset_pin_fuse,
  input  wire       pin5_general_io_permit,
  input  wire       pin4_general_io_permit,
  input  wire       outside_clock_source_sel,
  // raw pad levels, bits 7..4 and 0
  input  wire [4:0] pad_level,
  // bit 0 overrides
  output reg        b0_pullup_override_en,
  output reg        b0_pullup_override_val,
  output reg        b0_out_en_override_en,
  output reg        b0_out_en_override_val,
  output reg        b0_pin_value_override_en,
  output reg        b0_pin_value_override_val,
  output reg        b0_input_buffer_override_en,
  output reg        b0_input_buffer_override_val,
  output reg        pin_change_group0,
  // bits 7..4 overrides, index 3 is bit 7
  output reg  [3:0] hi_pullup_override_en,
  output reg  [3:0] hi_pullup_override_val,
  output reg  [3:0] hi_out_en_override_en,
  output reg  [3:0] hi_out_en_override_val,
  output reg  [3:0] hi_pin_value_override_en,
  output reg  [3:0] hi_pin_value_override_val,
  output reg  [3:0] hi_input_buffer_override_en,
  output reg  [3:0] hi_input_buffer_override_val,
  output reg        pin_change_group1_active,
  // synchronised pad levels for consumers
  output reg  [4:0] pad_level_sync
);

  // fuse is active low: zero keeps the reset function on the pin
  wire reset_pin_fuse_term = ~reset_pin_fuse;

  // pads come from outside the clock domain
  wire [4:0] pad_sync;

  pin_sync2 #(
    .WIDTH    (5)
  ) u_pad_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pad_level),
    .sync_out (pad_sync)
  );

  // an interrupt group is live only with the global enable
  function irq_gate;
    input glob;
    input grp;
    begin
      irq_gate = glob & grp;
    end
  endfunction

  // bit 0 combinational terms
  reg b0_pu_en_nxt;
  reg b0_dd_en_nxt;
  reg b0_dd_val_nxt;
  reg b0_pv_en_nxt;
  reg b0_pv_val_nxt;
  reg b0_ie_en_nxt;
  reg b0_wave_ok;
  reg b0_owned;
  reg pcg0_nxt;

  always @*
  begin
    b0_pu_en_nxt  = serial_two_wire_mode;
    // three-wire mode contributes nothing here: port stays in control
    b0_dd_en_nxt  = serial_two_wire_mode;
    // open collector: drive low if latch or shifter is zero
    b0_dd_val_nxt = (~serial_shift_out | ~port_bit0_out_latch)
                    & port_bit0_out_en;
    b0_wave_ok    = timer1_compare_a_en & ~programming_active
                    & ~serial_two_wire_mode & ~serial_three_wire_mode
                    & port_bit0_out_en;
    b0_pv_en_nxt  = (serial_two_wire_mode & port_bit0_out_en) | b0_wave_ok;
    // two-wire data line is pulled low only via direction, value held 0
    b0_pv_val_nxt = ~(serial_two_wire_mode & port_bit0_out_en)
                    & b0_wave_ok & ~timer1_compare_a_wave;
    b0_owned      = serial_two_wire_mode | serial_three_wire_mode | b0_wave_ok;
    pcg0_nxt      = irq_gate(global_irq_en, group0_change_irq_en)
                    & ~b0_owned;
    b0_ie_en_nxt  = pcg0_nxt | serial_start_irq_active;
  end

  // bits 7..4 combinational terms
  reg       pcg1_nxt;
  reg [3:0] hi_pu_en_nxt;
  reg [3:0] hi_pu_val_nxt;
  reg [3:0] hi_dd_en_nxt;
  reg [3:0] hi_ie_en_nxt;
  reg [3:0] hi_ie_val_nxt;

  always @*
  begin
    // occupancy: reset on bit 7, low-level irq0 or timer0 clock on bit 6, crystal on bits 5,4
    pcg1_nxt = irq_gate(global_irq_en, group1_change_irq_en)
               & ~reset_pin_fuse_term & ~ext_irq0_active
               & ~timer0_outside_clock_sel
               & pin5_general_io_permit & pin4_general_io_permit;
    // bit 7: reset pin
    hi_pu_en_nxt[`HI_B7]  = reset_pin_fuse_term;
    hi_pu_val_nxt[`HI_B7] = `OVR_ON;
    hi_dd_en_nxt[`HI_B7]  = reset_pin_fuse_term;
    hi_ie_en_nxt[`HI_B7]  = pcg1_nxt | reset_pin_fuse_term;
    hi_ie_val_nxt[`HI_B7] = pcg1_nxt & ~reset_pin_fuse_term;
    // bit 6: irq0 and timer0 clock never touch port controls
    hi_pu_en_nxt[`HI_B6]  = `OVR_OFF;
    hi_pu_val_nxt[`HI_B6] = `OVR_OFF;
    hi_dd_en_nxt[`HI_B6]  = `OVR_OFF;
    hi_ie_en_nxt[`HI_B6]  = (~timer0_outside_clock_sel & pcg1_nxt)
                            | ext_irq0_active;
    hi_ie_val_nxt[`HI_B6] = `OVR_ON;
    // bit 5: crystal output
    hi_pu_en_nxt[`HI_B5]  = ~pin5_general_io_permit;
    hi_pu_val_nxt[`HI_B5] = `OVR_OFF;
    hi_dd_en_nxt[`HI_B5]  = ~pin5_general_io_permit;
    hi_ie_en_nxt[`HI_B5]  = pcg1_nxt | ~pin5_general_io_permit;
    hi_ie_val_nxt[`HI_B5] = pcg1_nxt & pin5_general_io_permit;
    // bit 4: crystal input or outside clock
    hi_pu_en_nxt[`HI_B4]  = ~pin4_general_io_permit;
    hi_pu_val_nxt[`HI_B4] = `OVR_OFF;
    hi_dd_en_nxt[`HI_B4]  = ~pin4_general_io_permit;
    hi_ie_en_nxt[`HI_B4]  = pcg1_nxt | ~pin4_general_io_permit
                            | outside_clock_source_sel;
    hi_ie_val_nxt[`HI_B4] = (pcg1_nxt & pin4_general_io_permit)
                            | outside_clock_source_sel;
  end

  // register all outputs; reset leaves every override off so the port rules
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      b0_pullup_override_en        <= `OUT_RST_VAL;
      b0_pullup_override_val       <= `OUT_RST_VAL;
      b0_out_en_override_en        <= `OUT_RST_VAL;
      b0_out_en_override_val       <= `OUT_RST_VAL;
      b0_pin_value_override_en     <= `OUT_RST_VAL;
      b0_pin_value_override_val    <= `OUT_RST_VAL;
      b0_input_buffer_override_en  <= `OUT_RST_VAL;
      b0_input_buffer_override_val <= `OUT_RST_VAL;
      pin_change_group0            <= `OUT_RST_VAL;
      hi_pullup_override_en        <= {4{`OUT_RST_VAL}};
      hi_pullup_override_val       <= {4{`OUT_RST_VAL}};
      hi_out_en_override_en        <= {4{`OUT_RST_VAL}};
      hi_out_en_override_val       <= {4{`OUT_RST_VAL}};
      hi_pin_value_override_en     <= {4{`OUT_RST_VAL}};
      hi_pin_value_override_val    <= {4{`OUT_RST_VAL}};
      hi_input_buffer_override_en  <= {4{`OUT_RST_VAL}};
      hi_input_buffer_override_val <= {4{`OUT_RST_VAL}};
      pin_change_group1_active     <= `OUT_RST_VAL;
      pad_level_sync               <= {5{`OUT_RST_VAL}};
    end
    else
    begin
      b0_pullup_override_en        <= b0_pu_en_nxt;
      b0_pullup_override_val       <= `OVR_OFF;
      b0_out_en_override_en        <= b0_dd_en_nxt;
      b0_out_en_override_val       <= b0_dd_val_nxt;
      b0_pin_value_override_en     <= b0_pv_en_nxt;
      b0_pin_value_override_val    <= b0_pv_val_nxt;
      b0_input_buffer_override_en  <= b0_ie_en_nxt;
      b0_input_buffer_override_val <= `OVR_ON;
      pin_change_group0            <= pcg0_nxt;
      hi_pullup_override_en        <= hi_pu_en_nxt;
      hi_pullup_override_val       <= hi_pu_val_nxt;
      hi_out_en_override_en        <= hi_dd_en_nxt;
      // direction override always means input
      hi_out_en_override_val       <= {4{`OVR_OFF}};
      // output value never overridden on the upper nibble
      hi_pin_value_override_en     <= {4{`OVR_OFF}};
      hi_pin_value_override_val    <= {4{`OVR_OFF}};
      hi_input_buffer_override_en  <= hi_ie_en_nxt;
      hi_input_buffer_override_val <= hi_ie_val_nxt;
      pin_change_group1_active     <= pcg1_nxt;
      pad_level_sync               <= pad_sync;
    end
  end

endmodule // port_b_alt_function_override

// [testbench/port_b_alt_function_override_asserts.sv]
// Purpose: assertions on the port b override outputs
// Assumes: every override output lags its cause by one clock
// Notes:   bound to every instance of the block
`timescale 1ns/1ps

module port_b_alt_function_override_asserts (
  // clock and reset
  input logic       clk,
  input logic       reset_n,
  // control inputs of the block
  input logic       port_bit0_out_latch,
  input logic       port_bit0_out_en,
  input logic       serial_two_wire_mode,
  input logic       serial_three_wire_mode,
  input logic       serial_shift_out,
  input logic       serial_start_irq_active,
  input logic       programming_active,
  input logic       timer1_compare_a_en,
  input logic       timer1_compare_a_wave,
  input logic       global_irq_en,
  input logic       group0_change_irq_en,
  input logic       group1_change_irq_en,
  input logic       ext_irq0_active,
  input logic       timer0_outside_clock_sel,
  input logic       reset_pin_fuse,
  input logic       pin5_general_io_permit,
  input logic       pin4_general_io_permit,
  input logic       outside_clock_source_sel,
  input logic [4:0] pad_level,
  // override outputs
  input logic       b0_pullup_override_en,
  input logic       b0_pullup_override_val,
  input logic       b0_out_en_override_en,
  input logic       b0_out_en_override_val,
  input logic       b0_pin_value_override_en,
  input logic       b0_pin_value_override_val,
  input logic       b0_input_buffer_override_en,
  input logic       b0_input_buffer_override_val,
  input logic       pin_change_group0,
  input logic       pin_change_group1_active,
  input logic [3:0] hi_pullup_override_en,
  input logic [3:0] hi_pullup_override_val,
  input logic [3:0] hi_out_en_override_en,
  input logic [3:0] hi_out_en_override_val,
  input logic [3:0] hi_pin_value_override_en,
  input logic [3:0] hi_pin_value_override_val,
  input logic [3:0] hi_input_buffer_override_en,
  input logic [3:0] hi_input_buffer_override_val,
  input logic [4:0] pad_level_sync
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // the first edge after release still shows reset zeros, so wait one cycle
  sequence live_s; $past(reset_n); endsequence
  // the pad path needs three clean edges before its output means anything
  sequence up_s; reset_n [*4]; endsequence

  AST_B0_PULLUP: assert property (
    live_s |-> b0_pullup_override_en == $past(serial_two_wire_mode)
      && !b0_pullup_override_val)
    else $error("bit 0 pull-up override wrong");
  AST_B0_OPEN_DRAIN: assert property (
    live_s ##0 $past(serial_two_wire_mode) |-> b0_out_en_override_en
      && b0_out_en_override_val
      == $past((!serial_shift_out || !port_bit0_out_latch) && port_bit0_out_en))
    else $error("bit 0 open drain drive wrong");
  AST_B0_WAVE: assert property (
    live_s ##0 $past(timer1_compare_a_en && port_bit0_out_en && !serial_two_wire_mode
      && !serial_three_wire_mode && !programming_active)
      |-> b0_pin_value_override_en
      && b0_pin_value_override_val == !$past(timer1_compare_a_wave))
    else $error("bit 0 inverted wave wrong");
  AST_B0_CHANGE: assert property (
    live_s ##0 pin_change_group0 |-> $past(global_irq_en && group0_change_irq_en
      && !serial_two_wire_mode && !serial_three_wire_mode
      && !(timer1_compare_a_en && port_bit0_out_en && !programming_active)))
    else $error("bit 0 pin change live while masked");
  AST_B0_BUFFER: assert property (
    pin_change_group0 |-> b0_input_buffer_override_en && b0_input_buffer_override_val)
    else $error("bit 0 input buffer not kept on");
  AST_B7_RESET: assert property (
    live_s |-> hi_pullup_override_en[3] == !$past(reset_pin_fuse)
      && hi_out_en_override_en[3] == !$past(reset_pin_fuse)
      && hi_out_en_override_val == 4'h0)
    else $error("bit 7 reset overrides wrong");
  AST_B7_BUFFER: assert property (
    hi_input_buffer_override_en[3] == (pin_change_group1_active || hi_out_en_override_en[3])
      && hi_input_buffer_override_val[3]
      == (pin_change_group1_active && !hi_out_en_override_en[3]))
    else $error("bit 7 input buffer override wrong");
  AST_GROUP1: assert property (
    live_s |-> pin_change_group1_active == $past(global_irq_en && group1_change_irq_en
      && reset_pin_fuse && !ext_irq0_active && !timer0_outside_clock_sel
      && pin5_general_io_permit && pin4_general_io_permit))
    else $error("group 1 enable wrong");
  AST_B6_BUFFER: assert property (
    live_s |-> hi_input_buffer_override_val[2] && hi_input_buffer_override_en[2]
      == ($past(ext_irq0_active)
      || pin_change_group1_active && !$past(timer0_outside_clock_sel)))
    else $error("bit 6 input buffer override wrong");
  AST_B5_CRYSTAL: assert property (
    live_s |-> hi_pullup_override_en[1] == !$past(pin5_general_io_permit)
      && hi_input_buffer_override_val[1]
      == (pin_change_group1_active && $past(pin5_general_io_permit)))
    else $error("bit 5 crystal overrides wrong");
  AST_B4_CLOCK: assert property (
    live_s ##0 $past(outside_clock_source_sel)
      |-> hi_input_buffer_override_en[0] && hi_input_buffer_override_val[0])
    else $error("bit 4 clock input not forced");
  AST_HI_NO_VALUE: assert property (hi_pin_value_override_en == 4'h0)
    else $error("bits 7..4 override the output value");
  AST_PAD_SYNC: assert property (up_s |-> pad_level_sync == $past(pad_level, 3))
    else $error("pad level path latency wrong");
endmodule // port_b_alt_function_override_asserts

bind port_b_alt_function_override port_b_alt_function_override_asserts
  port_b_alt_function_override_asserts_inst (.*);

// [testbench/port_b_alt_function_override_tb_top.sv]
// Purpose: directed checks of the port b override outputs
// Assumes: outputs follow the control inputs one clock later
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps

module port_b_alt_function_override_tb_top;
  logic clk, reset_n, port_bit0_out_latch, port_bit0_out_en, serial_two_wire_mode;
  logic serial_three_wire_mode, serial_shift_out, serial_start_irq_active, programming_active;
  logic timer1_compare_a_en, timer1_compare_a_wave, global_irq_en, group0_change_irq_en;
  logic group1_change_irq_en, ext_irq0_active, timer0_outside_clock_sel, reset_pin_fuse;
  logic pin5_general_io_permit, pin4_general_io_permit, outside_clock_source_sel;
  logic b0_pullup_override_en, b0_pullup_override_val, b0_out_en_override_en;
  logic b0_out_en_override_val, b0_pin_value_override_en, b0_pin_value_override_val;
  logic b0_input_buffer_override_en, b0_input_buffer_override_val, pin_change_group0;
  logic pin_change_group1_active;
  logic [3:0] hi_pullup_override_en, hi_pullup_override_val, hi_out_en_override_en;
  logic [3:0] hi_out_en_override_val, hi_pin_value_override_en, hi_pin_value_override_val;
  logic [3:0] hi_input_buffer_override_en, hi_input_buffer_override_val;
  logic [4:0] pad_level, pad_level_sync;
  logic [17:0] v;
  logic [17:0] tbl [21];
  int n_errors, comparisons, i;
  // one vector holds every control input, so a scenario is one table row
  assign {outside_clock_source_sel, pin4_general_io_permit, pin5_general_io_permit,
    reset_pin_fuse, timer0_outside_clock_sel, ext_irq0_active, group1_change_irq_en,
    group0_change_irq_en, global_irq_en, timer1_compare_a_wave, timer1_compare_a_en,
    programming_active, serial_start_irq_active, serial_shift_out, serial_three_wire_mode,
    serial_two_wire_mode, port_bit0_out_en, port_bit0_out_latch} = v;
  wire [41:0] seen = {b0_pullup_override_en, b0_pullup_override_val, b0_out_en_override_en,
    b0_out_en_override_val, b0_pin_value_override_en, b0_pin_value_override_val,
    b0_input_buffer_override_en, b0_input_buffer_override_val, pin_change_group0,
    hi_pullup_override_en, hi_pullup_override_val, hi_out_en_override_en,
    hi_out_en_override_val, hi_pin_value_override_en, hi_pin_value_override_val,
    hi_input_buffer_override_en, hi_input_buffer_override_val, pin_change_group1_active};

  port_b_alt_function_override port_b_alt_function_override_inst (.*);

  // expected override terms, in the same order as seen
  function automatic logic [41:0] model(input logic [17:0] x);
    logic rs, g1, own, p0;
    rs = !x[14];
    g1 = x[9] & x[11] & !rs & !x[12] & !x[13] & x[15] & x[16];
    own = x[7] & x[1] & !x[2] & !x[3] & !x[6];
    p0 = x[9] & x[10] & !(x[2] | x[3] | own);
    return {x[2], 1'b0, x[2], (!x[4] | !x[0]) & x[1], x[2] & x[1] | own, own & !x[8],
      p0 | x[5], 1'b1, p0, rs, 1'b0, !x[15], !x[16], 4'h8, rs, 1'b0, !x[15], !x[16], 12'h000,
      g1 | rs, x[12] | g1 & !x[13], g1 | !x[15], g1 | !x[16] | x[17],
      g1 & !rs, 1'b1, g1 & x[15], g1 & x[16] | x[17], g1};
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] want);
    comparisons++;
    if (got !== want)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, want);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // free-running 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // the whole run is under 50 cycles, so 2 us means a hang
  initial
  begin
    #2000;
    n_errors++;
    give_verdict();
  end

  initial
  begin
    // rows: idle, two-wire, bit 0 change, wave, three-wire, group 1 and its masks
    tbl = '{18'h1C013, 18'h1C007, 18'h1C016, 18'h1C015, 18'h1C617, 18'h1C613, 18'h1C693,
      18'h1C793, 18'h1C6D3, 18'h1C097, 18'h1C60B, 18'h1C62B, 18'h1C213, 18'h1C033,
      18'h1CA13, 18'h18A13, 18'h1DA13, 18'h1EA13, 18'h14A13, 18'h2CA13, 18'h1C813};
    reset_n = 1'b0;
    v = 18'h1C013;
    pad_level = 5'h00;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    // a new row every cycle, so each row is also judged back to back
    for (i = 0; i < 21; i++)
    begin
      v = tbl[i];
      @(negedge clk);
      check(seen, model(v));
    end
    // pad levels arrive three cycles late
    pad_level = 5'h15;
    repeat (3) @(negedge clk);
    check(pad_level_sync, 5'h15);
    // the complementary pattern so that no pad bit can stick at its reset level
    pad_level = 5'h0A;
    repeat (3) @(negedge clk);
    check(pad_level_sync, 5'h0A);
    // reset in mid-run clears everything, then the block resumes
    reset_n = 1'b0;
    #1;
    check({seen, pad_level_sync}, 47'h0);
    @(negedge clk);
    reset_n = 1'b1;
    v = tbl[19];
    @(negedge clk);
    check(seen, model(v));
    give_verdict();
  end
endmodule // port_b_alt_function_override_tb_top
